/* common/scdp_pkg.sv */
// Purpose: Shared constants and types for the symbol clock and dibit port
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indices are word indices; byte address is four times the index
package scdp_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_MONITOR = 1;
  localparam int IDX_PORT_MODE = 6;
  localparam int IDX_STATUS = 8;
  localparam logic [ADDR_W-1:0] ADDR_MONITOR = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_PORT_MODE = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h020;

  // Rate select encodings
  localparam logic [1:0] RATE_64 = 2'h0;
  localparam logic [1:0] RATE_16 = 2'h1;
  localparam logic [1:0] RATE_32 = 2'h2;
  localparam logic [1:0] RATE_64B = 2'h3;

  // High-rate edges per symbol clock half period
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] HALF_16 = 6'h08;
  localparam logic [CNT_W-1:0] HALF_32 = 6'h10;
  localparam logic [CNT_W-1:0] HALF_64 = 6'h20;

  typedef struct packed {
    logic [3:0] monitorSource;
    logic [1:0] rateSelect;
  } scdp_monitor_t;

  typedef struct packed {
    logic lockEnable;
    logic rxRising;
    logic txRising;
    logic slaveMode;
  } scdp_port_mode_t;

  localparam scdp_monitor_t MONITOR_RESET = '{monitorSource: 4'h0, rateSelect: RATE_64};
  localparam scdp_port_mode_t PORT_MODE_RESET = '{lockEnable: 1'b0, rxRising: 1'b0,
                                                   txRising: 1'b0, slaveMode: 1'b0};
endpackage

/* hdl/scdp_clock_port.sv */
// Purpose: Symbol clock derivation and dibit channel port, master and slave modes
// Assumes: mclk 100 MHz; bit clocks and pins asynchronous to mclk
// Notes: High-rate clock is mclk divided by two
`timescale 1ns/10ps
module scdp_clock_port (
  // System
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scdp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clocks
  output logic highRateClock,
  output logic symbolClock,
  input wire logic recoveredTiming,
  // Channel unit pins
  input wire logic transmitBitClockIn,
  input wire logic receiveBitClockIn,
  input wire logic [1:0] transmitDibit,
  output logic [1:0] receiveDibit,
  // Transceiver core side
  input wire logic [1:0] coreReceiveDibit,
  output logic [1:0] coreTransmitDibit,
  output logic coreTransmitValid
);
  scdp_pkg::scdp_monitor_t monitorReg;
  scdp_pkg::scdp_port_mode_t portMode;
  logic [scdp_pkg::CNT_W-1:0] divCount;
  logic [scdp_pkg::CNT_W-1:0] halfCount;
  logic hRise;
  logic divWrap;
  logic symRise;
  logic symFall;
  logic [2:0] recSync;
  logic realignPending;
  logic locked;
  logic [1:0] txPinSync1;
  logic [1:0] txPinSync2;
  logic [1:0] masterRx;
  logic [1:0] rxHold;
  logic rxToggle;
  logic txPosToggle;
  logic txNegToggle;
  logic [1:0] txPosData;
  logic [1:0] txNegData;
  logic [2:0] txPosSync;
  logic [2:0] txNegSync;
  logic txSlaveEvent;
  logic [2:0] rxPosSync;
  logic [2:0] rxNegSync;
  logic [1:0] rxPosOut;
  logic [1:0] rxNegOut;
  logic [1:0] modeSync1;
  logic [1:0] modeSync2;
  logic access;
  logic [31:0] next_prdata;
  logic next_slverr;

  // Ratio decode
  always_comb begin
    if (monitorReg.rateSelect == scdp_pkg::RATE_16) begin
      halfCount = scdp_pkg::HALF_16;
    end else if (monitorReg.rateSelect == scdp_pkg::RATE_32) begin
      halfCount = scdp_pkg::HALF_32;
    end else begin
      halfCount = scdp_pkg::HALF_64;
    end
  end

  assign hRise = ~highRateClock;
  assign divWrap = (divCount >= halfCount - 6'h01);
  assign symRise = hRise && (realignPending || (divWrap && !symbolClock));
  assign symFall = hRise && !realignPending && divWrap && symbolClock;

  // High-rate clock
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      highRateClock <= 1'b0;
    end else begin
      highRateClock <= ~highRateClock;
    end
  end

  // Symbol clock divider, moves only with a high-rate rising edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      divCount <= 6'h00;
      symbolClock <= 1'b0;
    end else if (hRise) begin
      if (realignPending) begin
        divCount <= 6'h00;
        symbolClock <= 1'b1;
      end else if (divWrap) begin
        divCount <= 6'h00;
        symbolClock <= ~symbolClock;
      end else begin
        divCount <= divCount + 6'h01;
      end
    end
  end

  // Recovered timing; third stage only feeds the edge detector
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      recSync <= 3'h0;
    end else begin
      recSync <= {recSync[1:0], recoveredTiming};
    end
  end

  // Realign request; a fresh edge wins over the pending clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      realignPending <= 1'b0;
      locked <= 1'b0;
    end else begin
      if (portMode.lockEnable && recSync[1] && !recSync[2]) begin
        realignPending <= 1'b1;
      end else if (hRise) begin
        realignPending <= 1'b0;
      end
      if (!portMode.lockEnable) begin
        locked <= 1'b0;
      end else if (realignPending && hRise) begin
        locked <= 1'b1;
      end
    end
  end

  // Transmit pin synchroniser
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txPinSync1 <= 2'h0;
      txPinSync2 <= 2'h0;
    end else begin
      txPinSync1 <= transmitDibit;
      txPinSync2 <= txPinSync1;
    end
  end

  // Slave transmit capture on both edges; polarity picks one
  always_ff @(posedge transmitBitClockIn or posedge reset) begin
    if (reset) begin
      txPosData <= 2'h0;
      txPosToggle <= 1'b0;
    end else begin
      txPosData <= transmitDibit;
      txPosToggle <= ~txPosToggle;
    end
  end

  always_ff @(negedge transmitBitClockIn or posedge reset) begin
    if (reset) begin
      txNegData <= 2'h0;
      txNegToggle <= 1'b0;
    end else begin
      txNegData <= transmitDibit;
      txNegToggle <= ~txNegToggle;
    end
  end

  // Toggle crossings; data is held a full bit period, so it is stable when read
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txPosSync <= 3'h0;
      txNegSync <= 3'h0;
    end else begin
      txPosSync <= {txPosSync[1:0], txPosToggle};
      txNegSync <= {txNegSync[1:0], txNegToggle};
    end
  end

  assign txSlaveEvent = portMode.txRising ? (txPosSync[2] != txPosSync[1])
                                          : (txNegSync[2] != txNegSync[1]);

  // Transmit symbol to the core
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      coreTransmitDibit <= 2'h0;
      coreTransmitValid <= 1'b0;
    end else begin
      coreTransmitValid <= 1'b0;
      if (portMode.slaveMode) begin
        if (txSlaveEvent) begin
          coreTransmitDibit <= portMode.txRising ? txPosData : txNegData;
          coreTransmitValid <= 1'b1;
        end
      end else if (symFall) begin
        coreTransmitDibit <= txPinSync2;
        coreTransmitValid <= 1'b1;
      end
    end
  end

  // Receive symbol at symbol clock rise
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      masterRx <= 2'h0;
      rxHold <= 2'h0;
      rxToggle <= 1'b0;
    end else if (symRise) begin
      masterRx <= coreReceiveDibit;
      rxHold <= coreReceiveDibit;
      rxToggle <= ~rxToggle;
    end
  end

  // Slave receive launch, one register per edge
  always_ff @(posedge receiveBitClockIn or posedge reset) begin
    if (reset) begin
      rxPosSync <= 3'h0;
      rxPosOut <= 2'h0;
    end else begin
      rxPosSync <= {rxPosSync[1:0], rxToggle};
      if (rxPosSync[2] != rxPosSync[1]) begin
        rxPosOut <= rxHold;
      end
    end
  end

  always_ff @(negedge receiveBitClockIn or posedge reset) begin
    if (reset) begin
      rxNegSync <= 3'h0;
      rxNegOut <= 2'h0;
    end else begin
      rxNegSync <= {rxNegSync[1:0], rxToggle};
      if (rxNegSync[2] != rxNegSync[1]) begin
        rxNegOut <= rxHold;
      end
    end
  end

  // Mode bits are quasi-static, a plain two-stage sync suffices
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modeSync1 <= 2'h0;
      modeSync2 <= 2'h0;
    end else begin
      modeSync1 <= {portMode.slaveMode, portMode.rxRising};
      modeSync2 <= modeSync1;
    end
  end

  // Output select; only a mux of flops, mode changes are rare
  assign receiveDibit = !portMode.slaveMode ? masterRx
                      : (portMode.rxRising ? rxPosOut : rxNegOut);

  // APB: answer one cycle into the access phase
  assign access = psel && penable && !pready;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (paddr == scdp_pkg::ADDR_MONITOR) begin
      next_prdata[5:0] = {monitorReg.monitorSource, monitorReg.rateSelect};
    end else if (paddr == scdp_pkg::ADDR_PORT_MODE) begin
      next_prdata[3:0] = portMode;
    end else if (paddr == scdp_pkg::ADDR_STATUS) begin
      next_prdata[5:0] = {coreTransmitDibit, modeSync2, locked, symbolClock};
    end else begin
      next_slverr = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && next_slverr;
      if (access && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Register writes land on the edge that completes the transfer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      monitorReg <= scdp_pkg::MONITOR_RESET;
      portMode <= scdp_pkg::PORT_MODE_RESET;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == scdp_pkg::ADDR_MONITOR) begin
        monitorReg <= pwdata[5:0];
      end else if (paddr == scdp_pkg::ADDR_PORT_MODE) begin
        portMode <= pwdata[3:0];
      end
    end
  end
endmodule

/* verification/scdp_channel_unit.sv */
// Purpose: Channel unit framer model
// Assumes: Link clock much faster than symbols
// Notes: Bit clocks resample the symbol clock, so stay locked
`timescale 1ns/10ps
module scdp_channel_unit (
  // Clocks
  input wire logic linkClock,
  input wire logic symbolClock,
  // Mode
  input wire logic slaveMode,
  input wire logic txRising,
  // Pins
  output logic transmitBitClockIn,
  output logic receiveBitClockIn,
  output logic [1:0] transmitDibit
);
  logic [1:0] seen = 2'h0;
  initial {transmitBitClockIn, receiveBitClockIn, transmitDibit} = 4'h0;
  // Bit clocks still outside slave mode
  always @(posedge linkClock) begin
    seen <= {seen[0], symbolClock};
    transmitBitClockIn <= slaveMode & seen[0];
    receiveBitClockIn <= slaveMode & seen[1];
    if (slaveMode ? (transmitBitClockIn == txRising && seen[0] != txRising) : (seen[0] && !seen[1]))
      transmitDibit <= transmitDibit + 2'h1;
  end
endmodule

/* verification/scdp_clock_port_asserts.sv */
// Purpose: Port checks for the clock port
// Assumes: One mclk domain
// Notes: Mode bits are internal, so mode checks sit in tb
`timescale 1ns/10ps
module scdp_clock_port_asserts (
  // System
  input wire logic mclk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Clocks and core
  input wire logic highRateClock,
  input wire logic symbolClock,
  input wire logic coreTransmitValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  hr_edge_a: assert property ($changed(symbolClock) |-> $rose(highRateClock))
    else $error("symbol clock off edge");
  sym_high_a: assert property ($rose(symbolClock) |=> $stable(symbolClock) [*8])
    else $error("short high phase");
  sym_period_a: assert property ($changed(symbolClock) |-> ##[1:260] $changed(symbolClock))
    else $error("symbol clock stuck");
  ready_lat_a: assert property (psel && penable && !pready |=> pready)
    else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("long ready");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
    else $error("bad error read");
  tx_pulse_a: assert property (coreTransmitValid |=> !coreTransmitValid)
    else $error("long valid");
  cover property ($rose(symbolClock));
  cover property (pslverr);
  cover property (coreTransmitValid);
endmodule
bind scdp_clock_port scdp_clock_port_asserts i_scdp_clock_port_asserts (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .highRateClock(highRateClock), .symbolClock(symbolClock), .coreTransmitValid(coreTransmitValid));

/* verification/tb.sv */
// Purpose: Self-checking bench for the clock port
// Assumes: High-rate clock is mclk/2
// Notes: Rate 16 for traffic keeps the run short
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic mclk = 1'b0, linkClock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic recoveredTiming = 1'b0, prevSym = 1'b0, watch = 1'b0, pmSlave = 1'b0, pmTx = 1'b0, pmRx = 1'b0;
  logic pready, pslverr, rerr, highRateClock, symbolClock, transmitBitClockIn, receiveBitClockIn, coreTransmitValid;
  logic [scdp_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [1:0] transmitDibit, receiveDibit, coreTransmitDibit, coreReceiveDibit = '0;
  logic [7:0] half [4] = '{8'h40, 8'h10, 8'h20, 8'h40};
  int fails = 0, n_tests = 0, txCnt = 0, n = 0;
  realtime lastRx = 0;
  always #5 mclk = ~mclk;
  initial #3 forever #6 linkClock = ~linkClock;
  scdp_clock_port i_scdp_clock_port (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .highRateClock(highRateClock), .symbolClock(symbolClock), .recoveredTiming(recoveredTiming),
    .transmitBitClockIn(transmitBitClockIn), .receiveBitClockIn(receiveBitClockIn),
    .transmitDibit(transmitDibit), .receiveDibit(receiveDibit), .coreReceiveDibit(coreReceiveDibit),
    .coreTransmitDibit(coreTransmitDibit), .coreTransmitValid(coreTransmitValid));
  scdp_channel_unit i_scdp_channel_unit (.linkClock(linkClock), .symbolClock(symbolClock), .slaveMode(pmSlave),
    .txRising(pmTx), .transmitBitClockIn(transmitBitClockIn), .receiveBitClockIn(receiveBitClockIn),
    .transmitDibit(transmitDibit));
  always @(posedge mclk) begin
    if (watch && coreTransmitValid) begin
      txCnt++;
      `CHK("txDibit", transmitDibit, coreTransmitDibit)
    end
    if (watch && !pmSlave && symbolClock !== prevSym)
      `CHK("rxDibit", coreReceiveDibit - {1'b0, !symbolClock}, receiveDibit)
    if (symbolClock && !prevSym)
      coreReceiveDibit <= coreReceiveDibit + 2'h1;
    prevSym = symbolClock;
  end
  always @(receiveBitClockIn)
    if (receiveBitClockIn === pmRx)
      lastRx = $realtime;
  always @(receiveDibit)
    if (watch && pmSlave)
      `CHK("rxDelay", 1'b1, $realtime - lastRx <= 100.0)
  task conclude;
    $display("Checks %0d, errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [scdp_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge mclk);
    if (i == 20) begin
      fails++;
      conclude;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [scdp_pkg::ADDR_W-1:0] a, input logic [31:0] e, input logic er);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", e, rdat)
    `CHK("pslverr", er, rerr)
  endtask
  task mode(input logic [3:0] m);
    apb(1'b1, scdp_pkg::ADDR_PORT_MODE, 32'(m));
    {pmRx, pmTx, pmSlave} = m[2:0];
  endtask
  task waitSym(input logic v);
    n = 0;
    while (symbolClock !== v) begin
      @(posedge mclk);
      n++;
      if (n > 300) begin
        fails++;
        conclude;
      end
    end
  endtask
  task symbols(input int k);
    repeat (k) begin
      waitSym(1'b1);
      waitSym(1'b0);
    end
  endtask
  // Settle first: mode changes may glitch the pins
  task traffic;
    symbols(3);
    txCnt = 0;
    watch = 1'b1;
    symbols(6);
    watch = 1'b0;
    `CHK("txCount", 1'b1, txCnt >= 5)
  endtask
  task t_regs;
    rd(scdp_pkg::ADDR_MONITOR, 32'h0000_0000, 1'b0);
    rd(scdp_pkg::ADDR_PORT_MODE, 32'h0000_0000, 1'b0);
    apb(1'b1, scdp_pkg::ADDR_MONITOR, 32'hFFFF_FFE9);
    rd(scdp_pkg::ADDR_MONITOR, 32'h0000_0029, 1'b0);
    apb(1'b1, scdp_pkg::ADDR_PORT_MODE, 32'hFFFF_FFF6);
    rd(scdp_pkg::ADDR_PORT_MODE, 32'h0000_0006, 1'b0);
    rd(12'h100, 32'h0000_0000, 1'b1);
  endtask
  task t_rate;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, scdp_pkg::ADDR_MONITOR, 32'(r));
      symbols(2);
      waitSym(1'b1);
      waitSym(1'b0);
      `CHK("highLen", half[r], n[7:0])
      waitSym(1'b1);
      `CHK("lowLen", half[r], n[7:0])
    end
  endtask
  task t_lock;
    mode(4'h8);
    waitSym(1'b1);
    waitSym(1'b0);
    repeat (3) @(posedge mclk);
    recoveredTiming <= 1'b1;
    waitSym(1'b1);
    `CHK("lockFast", 1'b1, n < 10)
    recoveredTiming <= 1'b0;
    apb(1'b0, scdp_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("locked", 1'b1, rdat[1])
    mode(4'h0);
    apb(1'b0, scdp_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("unlocked", 1'b0, rdat[1])
  endtask
  task t_master;
    apb(1'b1, scdp_pkg::ADDR_MONITOR, 32'h0000_0001);
    traffic;
  endtask
  task t_slave;
    for (int m = 0; m < 4; m++) begin
      mode({1'b0, 2'(m), 1'b1});
      traffic;
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_regs;
    t_rate;
    t_lock;
    t_master;
    t_slave;
    conclude;
  end
endmodule
